// ==== hdl/card_socket_pkg.sv ====
// Shared constants and types for the card socket control logic
`default_nettype none
package card_socket_pkg;
	localparam int CLOCK_PERIOD_NS = 100;
	localparam int SETUP_TIME_NS = 100;
	localparam int STROBE_TIME_NS = 300;
	localparam int SETUP_CYCLES =
		(SETUP_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int STROBE_CYCLES =
		(STROBE_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int SYNC_STAGES = 2;
	localparam int COUNT_WIDTH = 4;

	typedef enum logic [2:0] {
		OP_MEM_RD,
		OP_MEM_WR,
		OP_IO_RD,
		OP_IO_WR,
		OP_DMA_RD,
		OP_DMA_WR
	} op_t;

	typedef struct packed {
		op_t op;
		logic attr;
		logic last;
	} cycle_req_t;

	typedef struct packed {
		logic output_enable_n;
		logic write_strobe_n;
		logic attr_select_n;
		logic io_read_strobe_n;
		logic io_write_strobe_n;
	} strobe_t;

	localparam strobe_t STROBE_IDLE = strobe_t'(5'h1f);

	typedef struct packed {
		logic memory_only;
		logic dma_enable;
	} card_cfg_t;

	typedef struct packed {
		logic ready;
		logic card_service_request;
		logic write_protect;
		logic io_port_is_wide;
		logic dma_request;
	} card_status_t;

	typedef enum logic [1:0] {
		VOLT_5V,
		VOLT_3V3,
		VOLT_LOW,
		VOLT_LOWEST
	} volt_t;
endpackage
`default_nettype wire

// ==== hdl/level_sync.sv ====
// Two flip-flop synchroniser for a bundle of levels
`default_nettype none
module level_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	// Destination clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// Levels
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] meta;

	// The first stage feeds only the second stage
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			meta <= INIT;
			dout <= INIT;
		end else begin
			meta <= din;
			dout <= meta;
		end
	end
endmodule
`default_nettype wire

// ==== hdl/socket_link_ctrl.sv ====
// Socket clock domain: socket reset release and clock-run handling
`default_nettype none
module socket_link_ctrl (
	// Socket clock and system reset
	input wire logic socket_bus_clock,
	input wire logic arst_n,
	// Levels from the system clock domain, all from flip-flops
	input wire logic reset_req,
	input wire logic slow_req,
	input wire logic stop_req,
	// Clock-run pin, tristate: driven high while enabled, otherwise released
	input wire logic socket_clock_run_request_in,
	output logic socket_clock_run_request_out,
	output logic socket_clock_run_request_oe,
	// Socket outputs
	output logic socket_bus_reset_n,
	output logic socket_park,
	output logic socket_clock_enable,
	output logic card_speedup
);
	import card_socket_pkg::*;

	logic link_arst_n;
	logic [1:0] release_pipe;
	logic [1:0] ctl_sync;
	logic run_sync;

	// Assertion is asynchronous; release walks three socket clock edges
	assign link_arst_n = arst_n & ~reset_req;

	always_ff @(posedge socket_bus_clock or negedge link_arst_n) begin
		if (!link_arst_n) begin
			release_pipe <= 2'h0;
			socket_bus_reset_n <= 1'b0;
			socket_park <= 1'b1;
		end else begin
			release_pipe <= {release_pipe[0], 1'b1};
			socket_bus_reset_n <= release_pipe[1];
			socket_park <= ~release_pipe[1];
		end
	end

	level_sync #(.WIDTH(2)) u_ctl_sync (
		.clock(socket_bus_clock),
		.arst_n(arst_n),
		.din({slow_req, stop_req}),
		.dout(ctl_sync)
	);

	// Clock-run passes two flip-flops on the socket clock edge before use
	level_sync #(.WIDTH(1), .INIT(1'b1)) u_run_sync (
		.clock(socket_bus_clock),
		.arst_n(arst_n),
		.din(socket_clock_run_request_in),
		.dout(run_sync)
	);

	// The socket clock is the free-running host bus clock; stopping
	// happens in the external gate, so this logic keeps its edges.
	always_ff @(posedge socket_bus_clock or negedge arst_n) begin
		if (!arst_n) begin
			socket_clock_run_request_out <= 1'b1;
			socket_clock_run_request_oe <= 1'b0;
			card_speedup <= 1'b0;
			socket_clock_enable <= 1'b1;
		end else begin
			socket_clock_run_request_out <= 1'b1;
			socket_clock_run_request_oe <= ctl_sync[1];
			card_speedup <= ~run_sync & ~ctl_sync[1];
			socket_clock_enable <= ~(ctl_sync[0] & run_sync);
		end
	end
endmodule
`default_nettype wire

// ==== hdl/card_socket_control.sv ====
// Socket control strobes, card status and socket clock/reset control
//
// Behaviour
// - Output enable low for memory reads
// - Output enable marks terminal count, DMA writes
// - Attribute select high for common memory
// - Attribute select picks attribute or I/O space
// - DMA acknowledge on attribute select with strobes
// - Card reset output forces hard reset
// - Wait stretches the current cycle
// - Write strobe clocks memory write data
// - Write strobe marks terminal count, DMA reads
// - Two voltage sense lines decoded together
// - Socket signals sampled on socket clock rise; card pins here are sampled on system clock rise
// - Socket clock at host rate, stoppable low
// - Clock-run: card speeds up, device slows
// - Socket reset parks card, device drives levels
// - Socket reset asserts async, releases synchronously
// - I/O read strobe is DMA write strobe
// - I/O write strobe latches I/O write data
`default_nettype none
module card_socket_control (
	// System clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// Socket clock
	input wire logic socket_bus_clock,
	// Cycle requests
	input wire logic req_valid,
	input wire card_socket_pkg::cycle_req_t req,
	output logic req_ready,
	output logic cycle_done,
	// Socket configuration and control levels
	input wire card_socket_pkg::card_cfg_t card_cfg,
	input wire logic card_reset_req,
	input wire logic socket_reset_req,
	input wire logic clock_slow_req,
	input wire logic clock_stop_req,
	// Card strobes
	output card_socket_pkg::strobe_t strobes,
	output logic card_reset,
	// Card inputs
	input wire logic ready_service_pin,
	input wire logic wait_n,
	input wire logic write_protect_pin,
	input wire logic voltage_sense_a,
	input wire logic voltage_sense_b,
	// Card status
	output card_socket_pkg::card_status_t card_status,
	output card_socket_pkg::volt_t card_voltage,
	output logic card_clock_boost,
	// Socket clock domain pins
	input wire logic socket_clock_run_request_in,
	output logic socket_clock_run_request_out,
	output logic socket_clock_run_request_oe,
	output logic socket_bus_reset_n,
	output logic socket_park,
	output logic socket_clock_enable
);
	import card_socket_pkg::*;

	typedef enum logic [1:0] {
		IDLE,
		SETUP,
		STROBE,
		RECOVER
	} state_t;

	localparam logic [COUNT_WIDTH-1:0] SETUP_LOAD =
		COUNT_WIDTH'(SETUP_CYCLES - 1);
	localparam logic [COUNT_WIDTH-1:0] STROBE_LOAD =
		COUNT_WIDTH'(STROBE_CYCLES - 1);

	state_t state;
	state_t next_state;
	logic [COUNT_WIDTH-1:0] count;
	logic [COUNT_WIDTH-1:0] next_count;
	cycle_req_t cur;
	strobe_t next_strobes;
	card_status_t next_status;
	logic [4:0] pins_sync;
	logic speedup_sync;
	logic socket_reset_level;
	logic ready_s;
	logic wait_active;
	logic wp_s;
	logic take;
	logic count_zero;
	cycle_req_t sel;
	logic card_speedup_link;
	logic slow_level;
	logic stop_level;

	// Strobe levels for one card cycle; pulse selects the data phase
	function automatic strobe_t drive(cycle_req_t r, logic pulse);
		strobe_t s;
		s = STROBE_IDLE;
		case (r.op)
			OP_MEM_RD: begin
				s.attr_select_n = ~r.attr;
				s.output_enable_n = ~pulse;
			end
			OP_MEM_WR: begin
				s.attr_select_n = ~r.attr;
				s.write_strobe_n = ~pulse;
			end
			OP_IO_RD: begin
				s.attr_select_n = 1'b0;
				s.io_read_strobe_n = ~pulse;
			end
			OP_IO_WR: begin
				s.attr_select_n = 1'b0;
				s.io_write_strobe_n = ~pulse;
			end
			OP_DMA_RD: begin
				s.attr_select_n = 1'b0;
				s.io_write_strobe_n = ~pulse;
				s.write_strobe_n = ~(pulse & r.last);
			end
			OP_DMA_WR: begin
				s.attr_select_n = 1'b0;
				s.io_read_strobe_n = ~pulse;
				s.output_enable_n = ~(pulse & r.last);
			end
			default: begin
				s = STROBE_IDLE;
			end
		endcase
		return s;
	endfunction

	// Combined code of both sense lines, both active low
	function automatic volt_t sense_code(logic a, logic b);
		volt_t v;
		v = VOLT_5V;
		case ({a, b})
			2'h3: v = VOLT_5V;
			2'h1: v = VOLT_3V3;
			2'h2: v = VOLT_LOW;
			default: v = VOLT_LOWEST;
		endcase
		return v;
	endfunction

	// Card pins are asynchronous to this clock
	level_sync #(.WIDTH(5), .INIT(5'h1f)) u_pin_sync (
		.clock(clock),
		.arst_n(arst_n),
		.din({ready_service_pin, wait_n, write_protect_pin,
			voltage_sense_a, voltage_sense_b}),
		.dout(pins_sync)
	);

	level_sync #(.WIDTH(1)) u_boost_sync (
		.clock(clock),
		.arst_n(arst_n),
		.din(card_speedup_link),
		.dout(speedup_sync)
	);

	socket_link_ctrl u_link (
		.socket_bus_clock(socket_bus_clock),
		.arst_n(arst_n),
		.reset_req(socket_reset_level),
		.slow_req(slow_level),
		.stop_req(stop_level),
		.socket_clock_run_request_in(socket_clock_run_request_in),
		.socket_clock_run_request_out(socket_clock_run_request_out),
		.socket_clock_run_request_oe(socket_clock_run_request_oe),
		.socket_bus_reset_n(socket_bus_reset_n),
		.socket_park(socket_park),
		.socket_clock_enable(socket_clock_enable),
		.card_speedup(card_speedup_link)
	);

	assign ready_s = pins_sync[4];
	assign wait_active = ~pins_sync[3];
	assign wp_s = pins_sync[2];
	assign take = req_valid & req_ready;
	assign count_zero = (count == '0);
	assign sel = take ? req : cur;

	always_comb begin
		next_state = state;
		case (state)
			IDLE: begin
				if (take) begin
					next_state = SETUP;
				end
			end
			SETUP: begin
				if (count_zero) begin
					next_state = STROBE;
				end
			end
			STROBE: begin
				// The card may hold the cycle open indefinitely
				if (count_zero && !wait_active) begin
					next_state = RECOVER;
				end
			end
			RECOVER: begin
				next_state = IDLE;
			end
			default: begin
				next_state = IDLE;
			end
		endcase
	end

	assign next_count = (take) ? SETUP_LOAD :
		(state == SETUP && count_zero) ? STROBE_LOAD :
		(count_zero) ? count : count - 1'b1;

	assign next_strobes = (next_state == IDLE) ? STROBE_IDLE :
		drive(sel, next_state == STROBE);

	// Shared pins take their meaning from the configured card type
	assign next_status.ready = card_cfg.memory_only & ready_s;
	assign next_status.card_service_request =
		~card_cfg.memory_only & ~ready_s;
	assign next_status.write_protect =
		card_cfg.memory_only & wp_s;
	assign next_status.io_port_is_wide =
		~card_cfg.memory_only & ~card_cfg.dma_enable & ~wp_s;
	assign next_status.dma_request =
		card_cfg.dma_enable & wp_s;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state <= IDLE;
			count <= '0;
			cur <= '0;
		end else begin
			state <= next_state;
			count <= next_count;
			cur <= take ? req : cur;
		end
	end

	// New cycles wait while the card is held in reset
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			req_ready <= 1'b0;
			cycle_done <= 1'b0;
			strobes <= STROBE_IDLE;
			card_reset <= 1'b1;
		end else begin
			req_ready <= (next_state == IDLE) & ~card_reset_req;
			cycle_done <= (state == RECOVER);
			strobes <= next_strobes;
			card_reset <= card_reset_req;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			card_status <= '0;
			card_voltage <= VOLT_5V;
			card_clock_boost <= 1'b0;
			socket_reset_level <= 1'b1;
			slow_level <= 1'b0;
			stop_level <= 1'b0;
		end else begin
			card_status <= next_status;
			card_voltage <= sense_code(pins_sync[1], pins_sync[0]);
			card_clock_boost <= speedup_sync;
			socket_reset_level <= socket_reset_req;
			slow_level <= clock_slow_req;
			stop_level <= clock_stop_req;
		end
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!arst_n);

	sequence s_take;
		req_valid && req_ready;
	endsequence

	sequence s_pulse_phase;
		state == SETUP ##1 state == STROBE [*3];
	endsequence

	a_strobe_width: assert property (
		s_take |=> s_pulse_phase)
		else $error("data strobe phase shorter than minimum");
	a_mem_read_oe: assert property (
		state == STROBE && cur.op == OP_MEM_RD |-> !strobes.output_enable_n)
		else $error("output enable not low in memory read");
	a_mem_write_we: assert property (
		state == STROBE && cur.op == OP_MEM_WR
		|-> !strobes.write_strobe_n && strobes.output_enable_n)
		else $error("write strobe not low in memory write");
	a_common_reg_high: assert property (
		state != IDLE && !cur.attr
		&& (cur.op == OP_MEM_RD || cur.op == OP_MEM_WR)
		|-> strobes.attr_select_n)
		else $error("attribute select low in common access");
	a_io_space_sel: assert property (
		state == STROBE && cur.op == OP_IO_WR
		|-> !strobes.attr_select_n && !strobes.io_write_strobe_n)
		else $error("I/O write not in I/O space");
	a_io_read_space: assert property (
		state == STROBE && cur.op == OP_IO_RD
		|-> !strobes.attr_select_n && !strobes.io_read_strobe_n)
		else $error("I/O read not in I/O space");
	a_idle_quiet: assert property (
		state == IDLE |-> strobes == STROBE_IDLE)
		else $error("strobes active outside a cycle");
	a_done_pulse: assert property (
		state == RECOVER |=> cycle_done ##1 !cycle_done)
		else $error("cycle done not a single pulse");
	a_reset_follow: assert property (
		!card_reset_req |=> !card_reset)
		else $error("card reset held without request");
	a_dma_write_tc: assert property (
		state == STROBE && cur.op == OP_DMA_WR
		|-> !strobes.attr_select_n && !strobes.io_read_strobe_n
		&& strobes.output_enable_n == !cur.last)
		else $error("DMA write strobes or count wrong");
	a_dma_read_tc: assert property (
		state == STROBE && cur.op == OP_DMA_RD
		|-> !strobes.attr_select_n && !strobes.io_write_strobe_n
		&& strobes.write_strobe_n == !cur.last)
		else $error("DMA read strobes or count wrong");
	a_wait_hold: assert property (
		state == STROBE && wait_active |=> state == STROBE)
		else $error("cycle ended while card waits");
	a_card_reset: assert property (
		card_reset_req |=> card_reset ##0 !req_ready)
		else $error("card reset not driven");
	a_status_type: assert property (
		card_cfg.memory_only && $stable(card_cfg) |=>
		!card_status.card_service_request && !card_status.io_port_is_wide)
		else $error("I/O status shown for memory card");
endmodule
`default_nettype wire

// ==== verif/card_model.sv ====
// Card model: pins as an inserted 16-bit card drives them
`default_nettype none
module card_model
	import card_socket_pkg::*;
(
	// Clock and socket view
	input wire logic clock,
	input wire card_socket_pkg::card_cfg_t card_cfg,
	input wire card_socket_pkg::strobe_t strobes,
	// Card state set by the bench
	input wire logic [4:0] state,
	input wire logic [3:0] wait_len,
	input wire logic [1:0] vs_code,
	input wire logic speedup,
	// Pins
	input wire logic run_out,
	input wire logic run_oe,
	output logic ready_service_pin,
	output logic wait_n,
	output logic write_protect_pin,
	output logic voltage_sense_a,
	output logic voltage_sense_b,
	output logic run_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] seen = 4'h0;
	wire strobing = !(strobes.output_enable_n && strobes.write_strobe_n &&
		strobes.io_read_strobe_n && strobes.io_write_strobe_n);
	// Wait falls with the strobe, as a real card answers at once;
	// the host's two sync stages would miss a wait raised later
	always @(posedge clock) begin
		if (!strobing)
			seen <= 4'h0;
		else if (seen != 4'hf)
			seen <= seen + 4'h1;
	end
	// Outside a strobe the pin returns to its pull-up
	assign wait_n = !(strobing && seen < wait_len);
	// state = {busy, service, wide, switch, dma request}
	assign ready_service_pin = card_cfg.memory_only ? !state[4] :
		!state[3];
	assign write_protect_pin = card_cfg.dma_enable ? state[0] :
		card_cfg.memory_only ? state[1] :
		!state[2];
	assign voltage_sense_a = vs_code[1];
	assign voltage_sense_b = vs_code[0];
	// Open-drain wire with pull-up; card pulls low to ask for speed
	assign run_pin = run_oe ? run_out : !speedup;
endmodule
`default_nettype wire

// ==== verif/testbench.sv ====
// Self-checking bench for the card socket control block
`default_nettype none
module testbench;
	import card_socket_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 0, socket_bus_clock = 0, arst_n = 0, req_valid = 0;
	cycle_req_t req = '0;
	card_cfg_t card_cfg = 2'b10;
	logic card_reset_req = 0, socket_reset_req = 0;
	logic clock_slow_req = 0, clock_stop_req = 0, speedup = 0;
	logic [4:0] state = '0;
	logic [3:0] wait_len = '0;
	logic [1:0] vs_code = 2'b11;
	logic req_ready, cycle_done, card_reset, card_clock_boost;
	logic rdy_pin, wait_n, wp_pin, vsa, vsb, run_pin, run_out, run_oe;
	logic socket_bus_reset_n, socket_park, socket_clock_enable;
	strobe_t strobes;
	card_status_t card_status;
	volt_t card_voltage;
	int failures = 0, num_checks = 0, n0;
	localparam int BASE_LEN = SETUP_CYCLES + STROBE_CYCLES + 1;
	card_socket_control DUT (.clock(clock), .arst_n(arst_n),
		.socket_bus_clock(socket_bus_clock), .req_valid(req_valid),
		.req(req), .req_ready(req_ready), .cycle_done(cycle_done),
		.card_cfg(card_cfg), .card_reset_req(card_reset_req),
		.socket_reset_req(socket_reset_req),
		.clock_slow_req(clock_slow_req), .clock_stop_req(clock_stop_req),
		.strobes(strobes), .card_reset(card_reset),
		.ready_service_pin(rdy_pin), .wait_n(wait_n),
		.write_protect_pin(wp_pin), .voltage_sense_a(vsa),
		.voltage_sense_b(vsb), .card_status(card_status),
		.card_voltage(card_voltage), .card_clock_boost(card_clock_boost),
		.socket_clock_run_request_in(run_pin),
		.socket_clock_run_request_out(run_out),
		.socket_clock_run_request_oe(run_oe),
		.socket_bus_reset_n(socket_bus_reset_n), .socket_park(socket_park),
		.socket_clock_enable(socket_clock_enable));
	card_model card (.clock(clock), .card_cfg(card_cfg), .strobes(strobes),
		.state(state), .wait_len(wait_len), .vs_code(vs_code),
		.speedup(speedup), .run_out(run_out), .run_oe(run_oe),
		.ready_service_pin(rdy_pin), .wait_n(wait_n),
		.write_protect_pin(wp_pin), .voltage_sense_a(vsa),
		.voltage_sense_b(vsb), .run_pin(run_pin));
	always #50 clock = ~clock;
	always #32 socket_bus_clock = ~socket_bus_clock;
	// Release must land on a socket clock rising edge
	always @(posedge socket_bus_reset_n)
		check(socket_bus_clock, 1, "async release");

	task automatic check(input logic [7:0] got, input logic [7:0] exp,
		input string what);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic tick(input int k = 1);
		repeat (k) @(posedge clock);
		#10;
	endtask

	// Strobe levels in the middle of the strobe phase
	function automatic strobe_t mid(input op_t op, input logic a,
		input logic l);
		case (op)
			OP_MEM_RD: mid = {1'b0, 1'b1, !a, 2'b11};
			OP_MEM_WR: mid = {1'b1, 1'b0, !a, 2'b11};
			OP_IO_RD: mid = 5'b11001;
			OP_IO_WR: mid = 5'b11010;
			OP_DMA_RD: mid = {1'b1, !l, 3'b010};
			default: mid = {!l, 4'b1001};
		endcase
	endfunction

	task automatic run_op(input op_t op, input logic a, input logic l,
		input logic [3:0] wl, output int n);
		int k;
		wait_len = wl;
		for (k = 0; k < 50 && req_ready !== 1'b1; k++)
			tick();
		check(req_ready, 1, "ready for cycle");
		req = '{op: op, attr: a, last: l};
		req_valid = 1;
		tick();
		req_valid = 0;
		for (n = 0; n < 60 && cycle_done !== 1'b1; n++) begin
			tick();
			if (n == 2)
				check(strobes, mid(op, a, l), "mid strobes");
		end
		check(cycle_done, 1, "cycle done");
		check(strobes, STROBE_IDLE, "strobes after");
		tick();
		check(cycle_done, 0, "done pulse");
	endtask

	task automatic t_cycles();
		int n;
		for (int o = 0; o < 6; o++)
			for (int v = 0; v < 4; v++) begin
				run_op(op_t'(o), v[0], v[1], 4'h0, n);
				check(n, BASE_LEN, "cycle length");
				n0 = n;
			end
	endtask

	task automatic t_wait();
		int n;
		run_op(OP_MEM_WR, 0, 0, 4'h6, n);
		check(n > n0 + 2, 1, "wait stretch");
		run_op(OP_IO_WR, 1, 0, 4'h6, n);
		check(n > n0 + 2, 1, "wait stretch io");
	endtask

	task automatic t_card_reset();
		card_reset_req = 1;
		tick(2);
		check(card_reset, 1, "card reset");
		check(req_ready, 0, "refused in reset");
		card_reset_req = 0;
		tick(2);
		check(card_reset, 0, "card reset off");
	endtask

	task automatic status_case(input card_cfg_t c, input logic [4:0] s,
		input logic [4:0] mask, input logic [4:0] exp);
		card_cfg = c;
		state = s;
		tick(5);
		check(card_status & mask, exp, "status");
	endtask

	task automatic t_status();
		status_case(2'b10, 5'b10010, 5'b10100, 5'b00100);
		status_case(2'b10, 5'b00000, 5'b10100, 5'b10000);
		status_case(2'b00, 5'b01100, 5'b01010, 5'b01010);
		status_case(2'b00, 5'b00000, 5'b01010, 5'b00000);
		status_case(2'b01, 5'b00001, 5'b00001, 5'b00001);
		status_case(2'b01, 5'b00000, 5'b00001, 5'b00000);
		card_cfg = 2'b10;
		state = '0;
	endtask

	task automatic t_voltage();
		volt_t map [4] = '{VOLT_LOWEST, VOLT_3V3, VOLT_LOW, VOLT_5V};
		for (int i = 0; i < 4; i++) begin
			vs_code = i[1:0];
			tick(4);
			check(card_voltage, map[i], "voltage code");
		end
	endtask

	task automatic t_socket();
		int k;
		socket_reset_req = 1;
		tick(2);
		check(socket_bus_reset_n, 0, "socket reset");
		check(socket_park, 1, "park");
		socket_reset_req = 0;
		for (k = 0; k < 20 && socket_bus_reset_n !== 1'b1; k++)
			tick();
		check(socket_bus_reset_n, 1, "socket release");
		check(socket_park, 0, "unpark");
	endtask

	task automatic t_clock_run();
		clock_slow_req = 1;
		tick(6);
		check(run_oe, 1, "slowdown notice");
		check(run_out, 1, "pin driven high");
		clock_slow_req = 0;
		clock_stop_req = 1;
		tick(6);
		check(run_oe, 0, "pin released");
		check(socket_clock_enable, 0, "clock stop");
		check(card_clock_boost, 0, "no speed request");
		speedup = 1;
		tick(8);
		check(card_clock_boost, 1, "speed request");
		check(socket_clock_enable, 1, "clock kept");
		speedup = 0;
		clock_stop_req = 0;
		tick(8);
	endtask

	initial begin
		tick(6);
		arst_n = 1;
		check(strobes, STROBE_IDLE, "reset strobes");
		tick(10);
		check(socket_bus_reset_n, 1, "first release");
		t_cycles();
		t_wait();
		t_card_reset();
		t_status();
		t_voltage();
		t_socket();
		t_clock_run();
		print_verdict();
	end
endmodule
`default_nettype wire
